/* rtl/ufc_fifo_control.sv */
`timescale 1ns/1ps
// FIFO control register block with AXI4-Lite access
module ufc_fifo_control #(
    parameter int DEPTH = ufc_pkg::FIFO_DEPTH,
    parameter int PTR_W = $clog2(DEPTH),
    parameter int LVL_W = $clog2(DEPTH) + 1
) (
    input  wire logic                       REF_CLK,
    input  wire logic                       RESETN,
    input  wire logic [ufc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                       S_AXI_AWVALID,
    output logic                            S_AXI_AWREADY,
    input  wire logic [ufc_pkg::DATA_W-1:0] S_AXI_WDATA,
    input  wire logic [3:0]                 S_AXI_WSTRB,
    input  wire logic                       S_AXI_WVALID,
    output logic                            S_AXI_WREADY,
    output logic      [1:0]                 S_AXI_BRESP,
    output logic                            S_AXI_BVALID,
    input  wire logic                       S_AXI_BREADY,
    input  wire logic [ufc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic                       S_AXI_ARVALID,
    output logic                            S_AXI_ARREADY,
    output logic      [ufc_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic      [1:0]                 S_AXI_RRESP,
    output logic                            S_AXI_RVALID,
    input  wire logic                       S_AXI_RREADY,
    input  wire logic                       TX_PUSH,
    input  wire logic                       TX_POP,
    input  wire logic                       RX_PUSH,
    input  wire logic                       RX_POP,
    output logic                            TX_FIFO_CLEAR,
    output logic                            RX_FIFO_CLEAR,
    output logic      [PTR_W-1:0]           TX_WR_PTR,
    output logic      [PTR_W-1:0]           TX_RD_PTR,
    output logic      [PTR_W-1:0]           RX_WR_PTR,
    output logic      [PTR_W-1:0]           RX_RD_PTR,
    output logic      [LVL_W-1:0]           TX_LEVEL,
    output logic      [LVL_W-1:0]           RX_LEVEL,
    output logic                            TX_EMPTY,
    output logic                            RX_EMPTY,
    output logic                            RX_DATA_AVAIL_IRQ,
    output logic                            IRQ
);
    import ufc_pkg::*;

    // Threshold code to byte count; unlisted codes saturate at 62
    function automatic logic [7:0] thr_level(input logic [THR_W-1:0] sel);
        logic [7:0] lvl;
        lvl = LVL_62;
        case (sel)
            4'h0:    lvl = LVL_1;
            4'h1:    lvl = LVL_4;
            4'h2:    lvl = LVL_8;
            4'h3:    lvl = LVL_14;
            4'h4:    lvl = LVL_30;
            4'h5:    lvl = LVL_46;
            default: lvl = LVL_62;
        endcase
        return lvl;
    endfunction

    // Place a narrow field into a bus word at a given bit
    function automatic logic [DATA_W-1:0] put_field(input logic [7:0] val,
                                                    input int         lsb);
        return DATA_W'(val) << lsb;
    endfunction

    // Write channel state
    logic              aw_ff,    nxt_aw;
    logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
    logic              w_ff,     nxt_w;
    logic [DATA_W-1:0] wdata_ff, nxt_wdata;
    logic [3:0]        wstrb_ff, nxt_wstrb;
    logic              bvalid_ff, nxt_bvalid;
    logic [1:0]        bresp_ff, nxt_bresp;
    logic              do_wr;

    // Read channel state
    logic              rvalid_ff, nxt_rvalid;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic [1:0]        rresp_ff, nxt_rresp;

    // Control state
    logic [THR_W-1:0]  thr_ff,   nxt_thr;
    logic              txclr_ff, nxt_txclr;
    logic              rxclr_ff, nxt_rxclr;
    logic              rda_ff,   nxt_rda;
    logic [IRQ_W-1:0]  ists_ff,  nxt_ists;
    logic [IRQ_W-1:0]  imask_ff, nxt_imask;
    logic              irq_ff,   nxt_irq;
    logic [IRQ_W-1:0]  ev_set;
    logic              fcr_wr_ok;

    // Tracker outputs
    logic [LVL_W-1:0]  tx_lvl;
    logic [LVL_W-1:0]  rx_lvl;
    logic              tx_empty;
    logic              rx_empty;

    // Write path: address and data taken in either order
    assign S_AXI_AWREADY = !aw_ff && !bvalid_ff;
    assign S_AXI_WREADY  = !w_ff && !bvalid_ff;
    assign do_wr         = aw_ff && w_ff && !bvalid_ff;

    always_comb begin
        nxt_aw     = aw_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w      = w_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            nxt_aw     = 1'b1;
            nxt_awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            nxt_w     = 1'b1;
            nxt_wdata = S_AXI_WDATA;
            nxt_wstrb = S_AXI_WSTRB;
        end
        if (do_wr) begin
            nxt_aw     = 1'b0;
            nxt_w      = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = RESP_OKAY;
            if (awaddr_ff[1:0] != 2'h0 || awaddr_ff == ADDR_STATUS) begin
                nxt_bresp = RESP_SLVERR;
            end
        end
        if (bvalid_ff && S_AXI_BREADY) begin
            nxt_bvalid = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            aw_ff     <= 1'b0;
            awaddr_ff <= '0;
            w_ff      <= 1'b0;
            wdata_ff  <= '0;
            wstrb_ff  <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else begin
            aw_ff     <= nxt_aw;
            awaddr_ff <= nxt_awaddr;
            w_ff      <= nxt_w;
            wdata_ff  <= nxt_wdata;
            wstrb_ff  <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff  <= nxt_bresp;
        end
    end

    // Read path: one read in flight, data registered
    assign S_AXI_ARREADY = !rvalid_ff;

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            nxt_rdata  = '0;
            case (S_AXI_ARADDR)
                ADDR_FCR: begin
                    nxt_rdata = put_field(8'(thr_ff), FCR_THR_LSB)
                              | put_field(8'h01, FCR_MODE_BIT);
                end
                ADDR_STATUS: begin
                    nxt_rdata = put_field(8'h01, STS_MODE_BIT)
                              | put_field(8'(thr_ff), STS_THR_LSB)
                              | put_field(8'(rda_ff), STS_RDA_BIT)
                              | put_field(8'(rx_empty), STS_RXEMPTY_BIT)
                              | put_field(8'(tx_empty), STS_TXEMPTY_BIT)
                              | put_field(8'(rx_lvl), STS_RXLVL_LSB)
                              | put_field(8'(tx_lvl), STS_TXLVL_LSB);
                end
                ADDR_IRQ_STS:  nxt_rdata = DATA_W'(ists_ff);
                ADDR_IRQ_MASK: nxt_rdata = DATA_W'(imask_ff);
                default:       nxt_rresp = RESP_SLVERR;
            endcase
        end else if (rvalid_ff && S_AXI_RREADY) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end

    // Control register, clear pulses, threshold compare and interrupts.
    // Control fields live in byte lane 0, so that lane must be enabled.
    always_comb begin
        fcr_wr_ok = do_wr && (awaddr_ff == ADDR_FCR) && wstrb_ff[0]
                    && wdata_ff[FCR_MODE_BIT];
        nxt_thr   = thr_ff;
        nxt_txclr = 1'b0;
        nxt_rxclr = 1'b0;
        if (fcr_wr_ok) begin
            nxt_thr   = wdata_ff[FCR_THR_LSB +: THR_W];
            nxt_txclr = wdata_ff[FCR_TXCLR_BIT];
            nxt_rxclr = wdata_ff[FCR_RXCLR_BIT];
            // dma select bit is not decoded
        end
        nxt_rda = (8'(rx_lvl) >= thr_level(thr_ff));
        ev_set = '0;
        ev_set[IRQ_RDA_BIT]   = nxt_rda && !rda_ff;
        ev_set[IRQ_TXCLR_BIT] = txclr_ff;
        ev_set[IRQ_RXCLR_BIT] = rxclr_ff;
        // Write one clears; a new event in the same cycle wins
        nxt_ists  = ists_ff;
        nxt_imask = imask_ff;
        if (do_wr && wstrb_ff[0] && awaddr_ff == ADDR_IRQ_STS) begin
            nxt_ists = ists_ff & ~wdata_ff[IRQ_W-1:0];
        end
        if (do_wr && wstrb_ff[0] && awaddr_ff == ADDR_IRQ_MASK) begin
            nxt_imask = wdata_ff[IRQ_W-1:0];
        end
        nxt_ists = nxt_ists | ev_set;
        nxt_irq  = |(nxt_ists & nxt_imask);
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            thr_ff   <= THR_RESET;
            txclr_ff <= 1'b0;
            rxclr_ff <= 1'b0;
            rda_ff   <= 1'b0;
            ists_ff  <= IRQ_RESET;
            imask_ff <= IRQ_RESET;
            irq_ff   <= 1'b0;
        end else begin
            thr_ff   <= nxt_thr;
            txclr_ff <= nxt_txclr;
            rxclr_ff <= nxt_rxclr;
            rda_ff   <= nxt_rda;
            ists_ff  <= nxt_ists;
            imask_ff <= nxt_imask;
            irq_ff   <= nxt_irq;
        end
    end

    ufc_fifo_track #(
        .DEPTH (DEPTH),
        .PTR_W (PTR_W),
        .LVL_W (LVL_W)
    ) u_tx_track (
        .clk    (REF_CLK),
        .rst_n  (RESETN),
        .clear  (txclr_ff),
        .push   (TX_PUSH),
        .pop    (TX_POP),
        .wr_ptr (TX_WR_PTR),
        .rd_ptr (TX_RD_PTR),
        .level  (tx_lvl),
        .empty  (tx_empty)
    );

    ufc_fifo_track #(
        .DEPTH (DEPTH),
        .PTR_W (PTR_W),
        .LVL_W (LVL_W)
    ) u_rx_track (
        .clk    (REF_CLK),
        .rst_n  (RESETN),
        .clear  (rxclr_ff),
        .push   (RX_PUSH),
        .pop    (RX_POP),
        .wr_ptr (RX_WR_PTR),
        .rd_ptr (RX_RD_PTR),
        .level  (rx_lvl),
        .empty  (rx_empty)
    );

    // Outputs
    assign S_AXI_BVALID      = bvalid_ff;
    assign S_AXI_BRESP       = bresp_ff;
    assign S_AXI_RVALID      = rvalid_ff;
    assign S_AXI_RDATA       = rdata_ff;
    assign S_AXI_RRESP       = rresp_ff;
    assign TX_FIFO_CLEAR     = txclr_ff;
    assign RX_FIFO_CLEAR     = rxclr_ff;
    assign TX_LEVEL          = tx_lvl;
    assign RX_LEVEL          = rx_lvl;
    assign TX_EMPTY          = tx_empty;
    assign RX_EMPTY          = rx_empty;
    assign RX_DATA_AVAIL_IRQ = rda_ff;
    assign IRQ               = irq_ff;
endmodule

/* rtl/ufc_fifo_track.sv */
`timescale 1ns/1ps
// Occupancy and pointer tracker for one FIFO
module ufc_fifo_track #(
    parameter int DEPTH = ufc_pkg::FIFO_DEPTH,
    parameter int PTR_W = $clog2(DEPTH),
    parameter int LVL_W = $clog2(DEPTH) + 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             push,
    input  wire logic             pop,
    output logic      [PTR_W-1:0] wr_ptr,
    output logic      [PTR_W-1:0] rd_ptr,
    output logic      [LVL_W-1:0] level,
    output logic                  empty
);
    import ufc_pkg::*;

    logic [PTR_W-1:0] wr_ff,  nxt_wr;
    logic [PTR_W-1:0] rd_ff,  nxt_rd;
    logic [LVL_W-1:0] lvl_ff, nxt_lvl;
    logic             do_push;
    logic             do_pop;

    // Pointer and level update; clear overrides traffic in its cycle
    always_comb begin
        do_push = push && (lvl_ff != LVL_W'(DEPTH));
        do_pop  = pop && (lvl_ff != '0);
        nxt_wr  = do_push ? PTR_W'(wr_ff + 1'b1) : wr_ff;
        nxt_rd  = do_pop ? PTR_W'(rd_ff + 1'b1) : rd_ff;
        nxt_lvl = lvl_ff;
        if (do_push && !do_pop) begin
            nxt_lvl = LVL_W'(lvl_ff + 1'b1);
        end else if (do_pop && !do_push) begin
            nxt_lvl = LVL_W'(lvl_ff - 1'b1);
        end
        if (clear) begin
            nxt_wr  = '0;
            nxt_rd  = '0;
            nxt_lvl = '0;
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            lvl_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            lvl_ff <= nxt_lvl;
        end
    end

    assign wr_ptr = wr_ff;
    assign rd_ptr = rd_ff;
    assign level  = lvl_ff;
    assign empty  = (lvl_ff == '0);
endmodule

/* rtl/ufc_pkg.sv */
package ufc_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_FCR      = 4'h0;
    localparam logic [3:0] ADDR_STATUS   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STS  = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
    localparam int         ADDR_W        = 4;
    localparam int         DATA_W        = 32;
    // Control register fields
    localparam int FCR_MODE_BIT = 0;
    localparam int FCR_RXCLR_BIT = 1;
    localparam int FCR_TXCLR_BIT = 2;
    localparam int FCR_DMA_BIT  = 3;
    localparam int FCR_THR_LSB  = 4;
    localparam int THR_W        = 4;
    // Status register fields
    localparam int STS_MODE_BIT   = 0;
    localparam int STS_THR_LSB    = 4;
    localparam int STS_RDA_BIT    = 8;
    localparam int STS_RXEMPTY_BIT = 9;
    localparam int STS_TXEMPTY_BIT = 10;
    localparam int STS_RXLVL_LSB  = 16;
    localparam int STS_TXLVL_LSB  = 24;
    // Interrupt event bits
    localparam int IRQ_W          = 3;
    localparam int IRQ_RDA_BIT    = 0;
    localparam int IRQ_TXCLR_BIT  = 1;
    localparam int IRQ_RXCLR_BIT  = 2;
    // Reset values and sizes
    localparam logic [THR_W-1:0] THR_RESET  = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_RESET  = 3'h0;
    localparam int               FIFO_DEPTH = 64;
    // Threshold levels in bytes
    localparam logic [7:0] LVL_1  = 8'h01;
    localparam logic [7:0] LVL_4  = 8'h04;
    localparam logic [7:0] LVL_8  = 8'h08;
    localparam logic [7:0] LVL_14 = 8'h0e;
    localparam logic [7:0] LVL_30 = 8'h1e;
    localparam logic [7:0] LVL_46 = 8'h2e;
    localparam logic [7:0] LVL_62 = 8'h3e;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* sim/ufc_fifo_control_props.sv */
`timescale 1ns/1ps
// Port-level checks on the FIFO control block
module ufc_fifo_control_props #(
    parameter int DEPTH = ufc_pkg::FIFO_DEPTH,
    parameter int PTR_W = $clog2(DEPTH),
    parameter int LVL_W = $clog2(DEPTH) + 1
) (
    input wire logic             REF_CLK,
    input wire logic             RESETN,
    input wire logic             S_AXI_AWREADY,
    input wire logic             S_AXI_WREADY,
    input wire logic             S_AXI_BVALID,
    input wire logic             S_AXI_ARVALID,
    input wire logic             S_AXI_ARREADY,
    input wire logic             S_AXI_RVALID,
    input wire logic             TX_FIFO_CLEAR,
    input wire logic             RX_FIFO_CLEAR,
    input wire logic [PTR_W-1:0] TX_WR_PTR,
    input wire logic [PTR_W-1:0] TX_RD_PTR,
    input wire logic [PTR_W-1:0] RX_WR_PTR,
    input wire logic [PTR_W-1:0] RX_RD_PTR,
    input wire logic [LVL_W-1:0] TX_LEVEL,
    input wire logic [LVL_W-1:0] RX_LEVEL,
    input wire logic             TX_EMPTY,
    input wire logic             RX_EMPTY,
    input wire logic             RX_DATA_AVAIL_IRQ
);
    // All checks live in the one oscillator clock domain
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    chk_txclr_pulse: assert property (
        TX_FIFO_CLEAR |=> !TX_FIFO_CLEAR)
        else $error("tx clear pulse longer than one cycle");
    chk_rxclr_pulse: assert property (
        RX_FIFO_CLEAR |=> !RX_FIFO_CLEAR)
        else $error("rx clear pulse longer than one cycle");
    chk_tx_emptied: assert property (TX_FIFO_CLEAR |=> TX_EMPTY
        && TX_LEVEL == 0 && TX_WR_PTR == 0 && TX_RD_PTR == 0)
        else $error("tx fifo not empty after clear");
    chk_rx_emptied: assert property (RX_FIFO_CLEAR |=> RX_EMPTY
        && RX_LEVEL == 0 && RX_WR_PTR == 0 && RX_RD_PTR == 0)
        else $error("rx fifo not empty after clear");
    // Clears only come from an accepted control write
    chk_clear_write: assert property ((TX_FIFO_CLEAR || RX_FIFO_CLEAR)
        |-> $rose(S_AXI_BVALID))
        else $error("clear pulse without a write response");
    // Level zero is below every threshold, 62 meets every threshold
    chk_rda_low: assert property (
        $past(RX_LEVEL) == 0 |-> !RX_DATA_AVAIL_IRQ)
        else $error("rx interrupt raised with empty fifo");
    chk_rda_high: assert property (
        $past(RX_LEVEL) >= 62 |-> RX_DATA_AVAIL_IRQ)
        else $error("rx interrupt low above highest threshold");
    chk_aw_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
    chk_r_latency: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data not one cycle after address");
    chk_r_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read accepted while data pending");

    cov_tx_clear: cover property (TX_FIFO_CLEAR);
    cov_both_clear: cover property (TX_FIFO_CLEAR && RX_FIFO_CLEAR);
    cov_rda_rise: cover property ($rose(RX_DATA_AVAIL_IRQ));
endmodule

bind ufc_fifo_control ufc_fifo_control_props #(
    .DEPTH(DEPTH), .PTR_W(PTR_W), .LVL_W(LVL_W)
) u_ufc_fifo_control_props (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .TX_FIFO_CLEAR(TX_FIFO_CLEAR),
    .RX_FIFO_CLEAR(RX_FIFO_CLEAR), .TX_WR_PTR(TX_WR_PTR),
    .TX_RD_PTR(TX_RD_PTR), .RX_WR_PTR(RX_WR_PTR), .RX_RD_PTR(RX_RD_PTR),
    .TX_LEVEL(TX_LEVEL), .RX_LEVEL(RX_LEVEL), .TX_EMPTY(TX_EMPTY),
    .RX_EMPTY(RX_EMPTY), .RX_DATA_AVAIL_IRQ(RX_DATA_AVAIL_IRQ)
);

/* sim/ufc_fifo_control_tb_top.sv */
`timescale 1ns/1ps
// Register-level bench for the FIFO control block
module ufc_fifo_control_tb_top;
    import ufc_pkg::*;
    logic              REF_CLK, RESETN;
    logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [DATA_W-1:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0]        S_AXI_WSTRB;
    logic [1:0]        S_AXI_BRESP, S_AXI_RRESP;
    logic              S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
    logic              S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
    logic              S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic              S_AXI_RREADY, TX_PUSH, TX_POP, RX_PUSH, RX_POP;
    logic              TX_FIFO_CLEAR, RX_FIFO_CLEAR, TX_EMPTY, RX_EMPTY;
    logic              RX_DATA_AVAIL_IRQ, IRQ;
    logic [5:0]        TX_WR_PTR, TX_RD_PTR, RX_WR_PTR, RX_RD_PTR;
    logic [6:0]        TX_LEVEL, RX_LEVEL;
    int                miscompares, n_checks, tx_pulses, rx_pulses;
    int                both_pulses, c, t;

    ufc_fifo_control u_ufc_fifo_control (
        .REF_CLK(REF_CLK), .RESETN(RESETN), .S_AXI_AWADDR(S_AXI_AWADDR),
        .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
        .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
        .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
        .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
        .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
        .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
        .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
        .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
        .TX_PUSH(TX_PUSH), .TX_POP(TX_POP), .RX_PUSH(RX_PUSH),
        .RX_POP(RX_POP), .TX_FIFO_CLEAR(TX_FIFO_CLEAR),
        .RX_FIFO_CLEAR(RX_FIFO_CLEAR), .TX_WR_PTR(TX_WR_PTR),
        .TX_RD_PTR(TX_RD_PTR), .RX_WR_PTR(RX_WR_PTR), .RX_RD_PTR(RX_RD_PTR),
        .TX_LEVEL(TX_LEVEL), .RX_LEVEL(RX_LEVEL), .TX_EMPTY(TX_EMPTY),
        .RX_EMPTY(RX_EMPTY), .RX_DATA_AVAIL_IRQ(RX_DATA_AVAIL_IRQ), .IRQ(IRQ)
    );

    // 100 MHz oscillator clock
    always #5 REF_CLK = ~REF_CLK;

    // Count clear-pulse cycles; a long pulse shows up as an extra count
    always @(posedge REF_CLK) begin
        if (RESETN === 1'b1) begin
            tx_pulses += int'(TX_FIFO_CLEAR === 1'b1);
            rx_pulses += int'(RX_FIFO_CLEAR === 1'b1);
            both_pulses += int'((TX_FIFO_CLEAR & RX_FIFO_CLEAR) === 1'b1);
        end
    end

    task automatic finish_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Handshakes are sampled at the falling edge, where all are settled
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        int n;
        logic aw_hs, w_hs, b_hs;
        logic [1:0] r;
        n = 0;
        b_hs = 1'b0;
        @(posedge REF_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        while (!b_hs && n < 100) begin
            @(negedge REF_CLK);
            aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
            w_hs = S_AXI_WVALID && S_AXI_WREADY;
            b_hs = S_AXI_BVALID && S_AXI_BREADY;
            r = S_AXI_BRESP;
            @(posedge REF_CLK);
            if (aw_hs) S_AXI_AWVALID <= 1'b0;
            if (w_hs) S_AXI_WVALID <= 1'b0;
            if (b_hs) S_AXI_BREADY <= 1'b0;
            n++;
        end
        check(32'(b_hs), 32'h1);
        check(32'(r), 32'(er));
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        int n;
        logic ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0] r;
        n = 0;
        r_hs = 1'b0;
        @(posedge REF_CLK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        while (!r_hs && n < 100) begin
            @(negedge REF_CLK);
            ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
            r_hs = S_AXI_RVALID && S_AXI_RREADY;
            {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
            @(posedge REF_CLK);
            if (ar_hs) S_AXI_ARVALID <= 1'b0;
            if (r_hs) S_AXI_RREADY <= 1'b0;
            n++;
        end
        check(32'(r_hs), 32'h1);
        check(d, ed);
        check(32'(r), 32'(er));
    endtask

    // Strobe order {TX_PUSH, TX_POP, RX_PUSH, RX_POP}; ends settled
    task automatic fifo_ops(input logic [3:0] s, input int n);
        repeat (n) begin
            @(posedge REF_CLK);
            {TX_PUSH, TX_POP, RX_PUSH, RX_POP} <= s;
        end
        @(posedge REF_CLK);
        {TX_PUSH, TX_POP, RX_PUSH, RX_POP} <= 4'h0;
        repeat (2) @(posedge REF_CLK);
        @(negedge REF_CLK);
    endtask

    function automatic int exp_thr(input int code);
        case (code)
            0: return 1;
            1: return 4;
            2: return 8;
            3: return 14;
            4: return 30;
            5: return 46;
            default: return 62;
        endcase
    endfunction

    // Hang guard, well past the expected run length
    initial begin
        #500000;
        miscompares++;
        finish_test();
    end

    initial begin
        {REF_CLK, RESETN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 5'h0;
        {S_AXI_ARVALID, S_AXI_RREADY, TX_PUSH, TX_POP, RX_PUSH} = 5'h0;
        {RX_POP, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB} = 13'h0;
        S_AXI_WDATA = 32'h0;
        repeat (8) @(posedge REF_CLK);
        RESETN <= 1'b1;
        rd_chk(ADDR_STATUS, 32'h601, RESP_OKAY);
        rd_chk(ADDR_FCR, 32'h1, RESP_OKAY);
        rd_chk(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
        // Every threshold code, each with an rx clear in the same write
        for (c = 0; c < 16; c++) begin
            t = exp_thr(c);
            wr(ADDR_FCR, 32'(c * 16 + 3), 4'hf, RESP_OKAY);
            @(negedge REF_CLK);
            check(32'(RX_LEVEL), 32'h0);
            rd_chk(ADDR_STATUS, 32'(32'h601 + c * 16), RESP_OKAY);
            fifo_ops(4'h2, t - 1);
            check(32'(RX_DATA_AVAIL_IRQ), 32'h0);
            fifo_ops(4'h2, 1);
            check(32'(RX_DATA_AVAIL_IRQ), 32'h1);
            fifo_ops(4'h1, 1);
            check(32'(RX_DATA_AVAIL_IRQ), 32'h0);
        end
        check(rx_pulses, 16);
        wr(ADDR_FCR, 32'h29, 4'hf, RESP_OKAY);
        rd_chk(ADDR_FCR, 32'h21, RESP_OKAY);
        wr(ADDR_FCR, 32'h76, 4'hf, RESP_OKAY);
        wr(ADDR_FCR, 32'h57, 4'he, RESP_OKAY);
        rd_chk(ADDR_FCR, 32'h21, RESP_OKAY);
        check(32'(RX_LEVEL), 32'h3d);
        check(rx_pulses + tx_pulses, 16);
        // Transmit clear with pointers away from zero
        fifo_ops(4'h8, 5);
        fifo_ops(4'h4, 2);
        check(32'(TX_WR_PTR), 32'h5);
        wr(ADDR_FCR, 32'h25, 4'hf, RESP_OKAY);
        @(negedge REF_CLK);
        check(tx_pulses, 1);
        check({TX_LEVEL, TX_WR_PTR, TX_RD_PTR, TX_EMPTY}, 32'h1);
        check(32'(RX_LEVEL), 32'h3d);
        rd_chk(ADDR_FCR, 32'h21, RESP_OKAY);
        fifo_ops(4'ha, 3);
        wr(ADDR_FCR, 32'h27, 4'hf, RESP_OKAY);
        @(negedge REF_CLK);
        check(both_pulses, 1);
        check({RX_LEVEL, RX_WR_PTR, RX_RD_PTR, RX_EMPTY}, 32'h1);
        check(32'(TX_EMPTY), 32'h1);
        rd_chk(ADDR_FCR, 32'h21, RESP_OKAY);
        // Interrupt status, mask and write-one-to-clear
        wr(ADDR_IRQ_STS, 32'h7, 4'hf, RESP_OKAY);
        rd_chk(ADDR_IRQ_STS, 32'h0, RESP_OKAY);
        wr(ADDR_IRQ_MASK, 32'h2, 4'hf, RESP_OKAY);
        check(32'(IRQ), 32'h0);
        wr(ADDR_FCR, 32'h05, 4'hf, RESP_OKAY);
        repeat (2) @(negedge REF_CLK);
        check(32'(IRQ), 32'h1);
        rd_chk(ADDR_IRQ_STS, 32'h2, RESP_OKAY);
        wr(ADDR_IRQ_MASK, 32'h0, 4'hf, RESP_OKAY);
        @(negedge REF_CLK);
        check(32'(IRQ), 32'h0);
        wr(ADDR_IRQ_MASK, 32'h2, 4'hf, RESP_OKAY);
        @(negedge REF_CLK);
        check(32'(IRQ), 32'h1);
        wr(ADDR_IRQ_STS, 32'h2, 4'hf, RESP_OKAY);
        @(negedge REF_CLK);
        check(32'(IRQ), 32'h0);
        // Refused accesses leave the control state alone
        wr(ADDR_STATUS, 32'h37, 4'hf, RESP_SLVERR);
        wr(4'h2, 32'h77, 4'hf, RESP_SLVERR);
        rd_chk(4'h6, 32'h0, RESP_SLVERR);
        rd_chk(ADDR_FCR, 32'h1, RESP_OKAY);
        check(rx_pulses + tx_pulses, 32'h14);
        finish_test();
    end
endmodule
